// *** error_measurement_gating.sv ***
// Measurement gating, live reporting and AXI4-Lite registers
`timescale 1ns/10ps
// What this block does
// - Time gating ends a period of whole seconds, 1 s to 99 d 23:59:59.
// - Clock gating ends with the second in which clocks reach 10^4..10^16.
// - Error gating ends with the second in which errors reach 10^4..10^16.
// - Mixed-pattern block gating ends with the second blocks reach 10^2..10^14.
// - Untimed cycles ignore the period and run from start to stop.
// - Repeat starts a fresh period whenever one ends.
// - Single runs one period and stops.
// - Live reports come every 100, 200 or 500 ms while measuring.
// - The 500 ms cadence is refused outside two-channel combination.
// - Progressive reports carry totals since start or the last period end.
// - Immediate reports carry only the last interval's counts.
// - Without live reports, the last period's result holds until the next ends.
module error_measurement_gating #(
  parameter int unsigned P_CYC_A = gating_pkg::CYC_A, // Cycles per 100 ms
  parameter int unsigned P_CYC_B = gating_pkg::CYC_B, // Cycles per 200 ms
  parameter int unsigned P_CYC_C = gating_pkg::CYC_C  // Cycles per 500 ms
) (
  input  wire logic        i_core_clk,      // Core clock, 250 MHz
  input  wire logic        i_rst,           // Synchronous reset, high
  input  wire logic        i_sec_level,     // One-second timebase pin
  input  wire logic [7:0]  i_clk_inc,       // Received clocks this cycle
  input  wire logic [7:0]  i_err_inc,       // Errors this cycle
  input  wire logic        i_blk_inc,       // One block completed
  input  wire logic        i_mixed_pattern, // Mixed block pattern active
  input  wire logic [7:0]  i_awaddr,        // AW address
  input  wire logic        i_awvalid,       // AW valid
  output logic             o_awready,       // AW ready
  input  wire logic [31:0] i_wdata,         // Write data
  input  wire logic [3:0]  i_wstrb,         // Write strobes
  input  wire logic        i_wvalid,        // W valid
  output logic             o_wready,        // W ready
  output logic [1:0]       o_bresp,         // Write response
  output logic             o_bvalid,        // B valid
  input  wire logic        i_bready,        // B ready
  input  wire logic [7:0]  i_araddr,        // AR address
  input  wire logic        i_arvalid,       // AR valid
  output logic             o_arready,       // AR ready
  output logic [31:0]      o_rdata,         // Read data
  output logic [1:0]       o_rresp,         // Read response
  output logic             o_rvalid,        // R valid
  input  wire logic        i_rready,        // R ready
  output logic             o_running,       // Measurement in progress
  output logic             o_report,        // Live report published
  output logic             o_period_end     // Period finished
);
  typedef enum logic {ST_IDLE, ST_RUN} meas_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  meas_state_t state;
  logic [1:0]  cycle_mode, gate_unit, ivl_sel;
  logic        live_en, immed, comb_mode, done_flag, reject_flag;
  logic        start_req, stop_req;
  logic [23:0] period_sec, elapsed;
  logic [4:0]  target_exp;
  logic [63:0] target, acc_clk, acc_err, acc_blk, int_clk, int_err, int_blk;
  logic [63:0] res_clk, res_err, res_blk;
  logic [23:0] res_sec;
  logic [31:0] rpt_cnt;
  logic        sec_tick;
  logic        aw_held, w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode helpers
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= gating_pkg::OFF_SECONDS);
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      gating_pkg::OFF_CTRL: begin
        v[gating_pkg::CTRL_CYC +: 2]  = cycle_mode;
        v[gating_pkg::CTRL_UNIT +: 2] = gate_unit;
        v[gating_pkg::CTRL_LIVE]      = live_en;
        v[gating_pkg::CTRL_IMMED]     = immed;
        v[gating_pkg::CTRL_IVL +: 2]  = ivl_sel;
        v[gating_pkg::CTRL_COMB]      = comb_mode;
      end
      gating_pkg::OFF_PERIOD:  v[23:0] = period_sec;
      gating_pkg::OFF_TARGET:  v[4:0]  = target_exp;
      gating_pkg::OFF_STATUS: begin
        v[gating_pkg::STAT_RUN]    = (state == ST_RUN);
        v[gating_pkg::STAT_DONE]   = done_flag;
        v[gating_pkg::STAT_REJECT] = reject_flag;
      end
      gating_pkg::OFF_CLK_LO:  v = res_clk[31:0];
      gating_pkg::OFF_CLK_HI:  v = res_clk[63:32];
      gating_pkg::OFF_ERR_LO:  v = res_err[31:0];
      gating_pkg::OFF_ERR_HI:  v = res_err[63:32];
      gating_pkg::OFF_BLK_LO:  v = res_blk[31:0];
      gating_pkg::OFF_BLK_HI:  v = res_blk[63:32];
      gating_pkg::OFF_SECONDS: v[23:0] = res_sec;
      default:                 v = 32'h0;
    endcase
    return v;
  endfunction

  // Exponent clamped to the unit's range
  function automatic logic [4:0] clamp_exp(input logic [4:0] e, input logic blk);
    logic [4:0] lo, hi;
    lo = blk ? gating_pkg::EXP_BMIN : gating_pkg::EXP_MIN;
    hi = blk ? gating_pkg::EXP_BMAX : gating_pkg::EXP_MAX;
    return (e < lo) ? lo : ((e > hi) ? hi : e);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write channel decode
  wire         do_write = aw_held & w_held & ~o_bvalid;
  wire         wr_ok    = mapped(aw_addr);
  logic [31:0] wr_old;
  logic [31:0] nv;
  always_comb begin
    wr_old = reg_read(aw_addr);
    for (int b = 0; b < 4; b++) begin
      nv[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : wr_old[b*8 +: 8];
    end
  end
  wire wr_ctrl   = do_write & (aw_addr == gating_pkg::OFF_CTRL);
  wire wr_period = do_write & (aw_addr == gating_pkg::OFF_PERIOD);
  wire wr_target = do_write & (aw_addr == gating_pkg::OFF_TARGET);
  wire wr_status = do_write & (aw_addr == gating_pkg::OFF_STATUS) & w_strb[0];
  wire [1:0] nv_ivl  = nv[gating_pkg::CTRL_IVL +: 2];
  wire ivl_refused = (nv_ivl == gating_pkg::IVL_500) & ~nv[gating_pkg::CTRL_COMB];
  wire [23:0] nv_per = (nv[23:0] < gating_pkg::PERIOD_MIN) ? gating_pkg::PERIOD_MIN :
                       (nv[23:0] > gating_pkg::PERIOD_MAX) ? gating_pkg::PERIOD_MAX :
                       nv[23:0];

  // AW and W latched apart, response follows both
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp  <= gating_pkg::RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_write) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= wr_ok ? gating_pkg::RESP_OKAY : gating_pkg::RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Registered readies
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
    end else begin
      o_awready <= ~aw_held & ~(i_awvalid & o_awready) & ~o_bvalid;
      o_wready  <= ~w_held & ~(i_wvalid & o_wready) & ~o_bvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0;
      o_rresp   <= gating_pkg::RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= reg_read(i_araddr);
      o_rresp   <= mapped(i_araddr) ? gating_pkg::RESP_OKAY : gating_pkg::RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end else if (!o_rvalid) begin
      o_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings and commands
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cycle_mode <= gating_pkg::CYC_REPEAT;
      gate_unit  <= gating_pkg::UNIT_TIME;
      live_en    <= 1'b0;
      immed      <= 1'b0;
      ivl_sel    <= gating_pkg::IVL_100;
      comb_mode  <= 1'b0;
      period_sec <= gating_pkg::RST_PERIOD;
      target_exp <= gating_pkg::RST_EXP;
      start_req  <= 1'b0;
      stop_req   <= 1'b0;
    end else begin
      start_req <= wr_ctrl & nv[gating_pkg::CTRL_START];
      stop_req  <= wr_ctrl & nv[gating_pkg::CTRL_STOP];
      if (wr_ctrl) begin
        cycle_mode <= nv[gating_pkg::CTRL_CYC +: 2];
        gate_unit  <= nv[gating_pkg::CTRL_UNIT +: 2];
        live_en    <= nv[gating_pkg::CTRL_LIVE];
        immed      <= nv[gating_pkg::CTRL_IMMED];
        comb_mode  <= nv[gating_pkg::CTRL_COMB];
        if (!ivl_refused) begin
          ivl_sel <= nv_ivl;
        end
      end
      if (wr_period) begin
        period_sec <= nv_per;
      end
      if (wr_target) begin
        target_exp <= nv[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase and target
  sec_tick_sync u_sec (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_level    (i_sec_level),
    .o_pulse    (sec_tick)
  );

  wire [4:0] eff_exp = clamp_exp(target_exp, gate_unit == gating_pkg::UNIT_BLOCK);

  decade_lut u_lut (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_exp      (eff_exp),
    .o_value    (target)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Gating decisions
  wire        running = (state == ST_RUN);
  wire [63:0] clk_x   = running ? {56'h0, i_clk_inc} : 64'h0;
  wire [63:0] err_x   = running ? {56'h0, i_err_inc} : 64'h0;
  wire [63:0] blk_x   = running ? {63'h0, i_blk_inc} : 64'h0;
  wire [63:0] acc_clk_s = acc_clk + clk_x;
  wire [63:0] acc_err_s = acc_err + err_x;
  wire [63:0] acc_blk_s = acc_blk + blk_x;
  wire [63:0] int_clk_s = int_clk + clk_x;
  wire [63:0] int_err_s = int_err + err_x;
  wire [63:0] int_blk_s = int_blk + blk_x;
  wire        tick_run  = running & sec_tick;
  wire [23:0] elapsed_s = 24'(elapsed + {23'h0, tick_run});
  wire goal_time  = elapsed_s >= period_sec;
  wire goal_clk   = acc_clk_s >= target;
  wire goal_err   = acc_err_s >= target;
  wire goal_blk   = i_mixed_pattern & (acc_blk_s >= target);
  wire goal_met   = (gate_unit == gating_pkg::UNIT_TIME)  ? goal_time :
                    (gate_unit == gating_pkg::UNIT_CLOCK) ? goal_clk  :
                    (gate_unit == gating_pkg::UNIT_ERROR) ? goal_err  : goal_blk;
  wire period_end = tick_run & goal_met & (cycle_mode != gating_pkg::CYC_UNTIMED);
  wire stop_cmd   = running & stop_req;
  wire finish     = period_end | stop_cmd;
  wire go_idle    = stop_cmd | (period_end & (cycle_mode != gating_pkg::CYC_REPEAT));
  wire clr_acc    = start_req | period_end;

  wire [31:0] ivl_len = (ivl_sel == gating_pkg::IVL_500) ? 32'(P_CYC_C) :
                        (ivl_sel == gating_pkg::IVL_200) ? 32'(P_CYC_B) : 32'(P_CYC_A);
  wire report_tick = running & live_en & (rpt_cnt >= ivl_len - 32'h1);
  wire clr_int     = clr_acc | report_tick;

  // Measurement state
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= start_req ? ST_RUN : ST_IDLE;
        ST_RUN:  state <= (go_idle && !start_req) ? ST_IDLE : ST_RUN;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      acc_clk <= 64'h0;
      acc_err <= 64'h0;
      acc_blk <= 64'h0;
      int_clk <= 64'h0;
      int_err <= 64'h0;
      int_blk <= 64'h0;
      elapsed <= 24'h0;
    end else begin
      acc_clk <= clr_acc ? 64'h0 : acc_clk_s;
      acc_err <= clr_acc ? 64'h0 : acc_err_s;
      acc_blk <= clr_acc ? 64'h0 : acc_blk_s;
      int_clk <= clr_int ? 64'h0 : int_clk_s;
      int_err <= clr_int ? 64'h0 : int_err_s;
      int_blk <= clr_int ? 64'h0 : int_blk_s;
      elapsed <= clr_acc ? 24'h0 : elapsed_s;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rpt_cnt <= 32'h0;
    end else if (clr_acc || report_tick || !running || !live_en) begin
      rpt_cnt <= 32'h0;
    end else begin
      rpt_cnt <= rpt_cnt + 32'h1;
    end
  end

  // Published results
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      res_clk <= 64'h0;
      res_err <= 64'h0;
      res_blk <= 64'h0;
      res_sec <= 24'h0;
    end else if (report_tick) begin
      res_clk <= immed ? int_clk_s : acc_clk_s;
      res_err <= immed ? int_err_s : acc_err_s;
      res_blk <= immed ? int_blk_s : acc_blk_s;
      res_sec <= elapsed_s;
    end else if (finish && !live_en) begin
      res_clk <= acc_clk_s;
      res_err <= acc_err_s;
      res_blk <= acc_blk_s;
      res_sec <= elapsed_s;
    end
  end

  // Sticky flags, set wins over clear; running, report and end outputs registered
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      done_flag    <= 1'b0;
      reject_flag  <= 1'b0;
      o_running    <= 1'b0;
      o_report     <= 1'b0;
      o_period_end <= 1'b0;
    end else begin
      done_flag    <= finish |
                      (done_flag & ~(wr_status & w_data[gating_pkg::STAT_DONE]));
      reject_flag  <= (wr_ctrl & ivl_refused) |
                      (reject_flag & ~(wr_status & w_data[gating_pkg::STAT_REJECT]));
      o_running    <= running;
      o_report     <= report_tick;
      o_period_end <= finish;
    end
  end
endmodule // error_measurement_gating

// *** gating_pkg.sv ***
// Constants shared by the measurement gating block
package gating_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_PERIOD  = 8'h04;
  localparam logic [7:0] OFF_TARGET  = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0c;
  localparam logic [7:0] OFF_CLK_LO  = 8'h10;
  localparam logic [7:0] OFF_CLK_HI  = 8'h14;
  localparam logic [7:0] OFF_ERR_LO  = 8'h18;
  localparam logic [7:0] OFF_ERR_HI  = 8'h1c;
  localparam logic [7:0] OFF_BLK_LO  = 8'h20;
  localparam logic [7:0] OFF_BLK_HI  = 8'h24;
  localparam logic [7:0] OFF_SECONDS = 8'h28;
  // Control field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP  = 1;
  localparam int CTRL_CYC   = 2;
  localparam int CTRL_UNIT  = 4;
  localparam int CTRL_LIVE  = 6;
  localparam int CTRL_IMMED = 7;
  localparam int CTRL_IVL   = 8;
  localparam int CTRL_COMB  = 10;
  // Status field positions
  localparam int STAT_RUN    = 0;
  localparam int STAT_DONE   = 1;
  localparam int STAT_REJECT = 2;
  // Cycle, unit and interval encodings
  localparam logic [1:0] CYC_REPEAT  = 2'h0;
  localparam logic [1:0] CYC_SINGLE  = 2'h1;
  localparam logic [1:0] CYC_UNTIMED = 2'h2;
  localparam logic [1:0] UNIT_TIME   = 2'h0;
  localparam logic [1:0] UNIT_CLOCK  = 2'h1;
  localparam logic [1:0] UNIT_ERROR  = 2'h2;
  localparam logic [1:0] UNIT_BLOCK  = 2'h3;
  localparam logic [1:0] IVL_100     = 2'h0;
  localparam logic [1:0] IVL_200     = 2'h1;
  localparam logic [1:0] IVL_500     = 2'h2;
  // Period limits in seconds, exponent limits
  localparam logic [23:0] PERIOD_MIN = 24'h000001;
  localparam logic [23:0] PERIOD_MAX = 24'h83d5ff;
  localparam logic [4:0]  EXP_MIN    = 5'h04;
  localparam logic [4:0]  EXP_MAX    = 5'h10;
  localparam logic [4:0]  EXP_BMIN   = 5'h02;
  localparam logic [4:0]  EXP_BMAX   = 5'h0e;
  // Values after reset
  localparam logic [23:0] RST_PERIOD = 24'h000001;
  localparam logic [4:0]  RST_EXP    = 5'h04;
  // Report cadences in ms and in core cycles
  localparam int CLK_MHZ  = 250;
  localparam int IVL_MS_A = 100;
  localparam int IVL_MS_B = 200;
  localparam int IVL_MS_C = 500;
  localparam int CYC_A    = IVL_MS_A * 1000 * CLK_MHZ;
  localparam int CYC_B    = IVL_MS_B * 1000 * CLK_MHZ;
  localparam int CYC_C    = IVL_MS_C * 1000 * CLK_MHZ;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** sec_tick_sync.sv ***
// Two-flop synchroniser and edge pulse for the second timebase
`timescale 1ns/10ps
module sec_tick_sync (
  input  wire logic i_core_clk, // Core clock
  input  wire logic i_rst,      // Synchronous reset
  input  wire logic i_level,    // Asynchronous timebase level
  output logic      o_pulse     // One-cycle pulse per rising edge
);
  logic meta;
  logic stable;
  logic prev;

  // Synchroniser chain and edge detect on the settled copy
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      meta    <= 1'b0;
      stable  <= 1'b0;
      prev    <= 1'b0;
      o_pulse <= 1'b0;
    end else begin
      meta    <= i_level;
      stable  <= meta;
      prev    <= stable;
      o_pulse <= stable & ~prev;
    end
  end
endmodule // sec_tick_sync

// *** decade_lut.sv ***
// Registered table of powers of ten for decade targets
`timescale 1ns/10ps
module decade_lut (
  input  wire logic        i_core_clk, // Core clock
  input  wire logic        i_rst,      // Synchronous reset
  input  wire logic [4:0]  i_exp,      // Decade exponent
  output logic      [63:0] o_value     // Ten to the exponent
);
  logic [63:0] table_val [17];

  // Elaboration-time power of ten
  function automatic logic [63:0] pow10(input int n);
    logic [63:0] v;
    v = 64'h1;
    for (int k = 0; k < n; k++) begin
      v = 64'(v * 64'ha);
    end
    return v;
  endfunction

  // One constant entry per exponent
  for (genvar g = 0; g < 17; g++) begin : g_tbl
    assign table_val[g] = pow10(g);
  end

  // Registered read
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_value <= 64'h0;
    end else begin
      o_value <= (i_exp > 5'h10) ? table_val[16] : table_val[i_exp];
    end
  end
endmodule // decade_lut

// *** error_measurement_gating_props.sv ***
// Concurrent checks on the gating block ports
`timescale 1ns/10ps
module error_measurement_gating_props (
  input wire logic        i_core_clk,   // Clock
  input wire logic        i_rst,        // Reset
  input wire logic        i_bready,     // B ready
  input wire logic        i_rready,     // R ready
  input wire logic        o_awready,    // AW ready
  input wire logic        o_wready,     // W ready
  input wire logic [1:0]  o_bresp,      // B response
  input wire logic        o_bvalid,     // B valid
  input wire logic        o_arready,    // AR ready
  input wire logic [31:0] o_rdata,      // R data
  input wire logic [1:0]  o_rresp,      // R response
  input wire logic        o_rvalid,     // R valid
  input wire logic        o_running,    // Measuring
  input wire logic        o_report,     // Report pulse
  input wire logic        o_period_end  // End pulse
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////
  // Bus handshakes
  a_bresp_held: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("bresp dropped");
  a_bvalid_ends: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("bvalid stuck");
  a_rdata_held: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)
    && $stable(o_rresp))
    else $error("rdata changed");
  a_aw_blocked: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken too soon");
  a_ar_blocked: assert property (o_rvalid |-> !o_arready)
    else $error("read taken too soon");
  // Measurement outputs
  a_report_gap: assert property (o_report |=> !o_report [*8])
    else $error("live reports too close");
  a_report_live: assert property (o_report |-> o_running || $past(o_running))
    else $error("live report while idle");
  a_end_pulse: assert property (o_period_end |=> !o_period_end)
    else $error("end pulse too long");
  a_reset_quiet: assert property (disable iff (1'b0) i_rst |=> !o_bvalid && !o_rvalid
    && !o_running && !o_report && !o_period_end)
    else $error("busy after reset");
endmodule // error_measurement_gating_props
bind error_measurement_gating error_measurement_gating_props error_measurement_gating_props_inst (
  .i_core_clk, .i_rst, .i_bready, .i_rready, .o_awready, .o_wready, .o_bresp, .o_bvalid,
  .o_arready, .o_rdata, .o_rresp, .o_rvalid, .o_running, .o_report, .o_period_end);

// *** tb_error_measurement_gating.sv ***
// Self-checking bench for the measurement gating block
`timescale 1ns/10ps
module tb_error_measurement_gating;
  logic        i_core_clk = 0, i_rst = 1, i_sec_level = 0, i_blk_inc = 0, i_mixed_pattern = 0;
  logic [7:0]  i_clk_inc = 0, i_err_inc = 0, i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0, seed = 32'h143754b3, c;
  logic [3:0]  i_wstrb = 4'hf;
  logic        i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_running, o_report;
  logic        o_period_end;
  logic [1:0]  o_bresp, o_rresp, rs;
  logic [31:0] o_rdata;
  logic [63:0] rv, sum;
  int          failures = 0, num_checks = 0, n, k2;
  // Block with short cadences
  error_measurement_gating #(.P_CYC_A(20), .P_CYC_B(40), .P_CYC_C(100))
    error_measurement_gating_inst (.i_core_clk, .i_rst, .i_sec_level, .i_clk_inc, .i_err_inc,
    .i_blk_inc, .i_mixed_pattern, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_running, .o_report, .o_period_end);
  // Clock at 250 MHz
  always #2 i_core_clk = ~i_core_clk;
  ////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] cw(input logic [1:0] cy, u, iv, input logic lv, im);
    cw = 0;
    cw[gating_pkg::CTRL_CYC +: 2] = cy;
    cw[gating_pkg::CTRL_UNIT +: 2] = u;
    cw[gating_pkg::CTRL_IVL +: 2] = iv;
    cw[gating_pkg::CTRL_LIVE] = lv;
    cw[gating_pkg::CTRL_IMMED] = im;
    cw[gating_pkg::CTRL_COMB] = (iv == gating_pkg::IVL_500);
  endfunction
  function automatic logic [63:0] gap(input logic [1:0] iv);
    return iv == gating_pkg::IVL_200 ? 40 : (iv == gating_pkg::IVL_500 ? 100 : 20);
  endfunction
  ////////////////////////////////////////////////////////////
  // Verdict, compare and bus tasks
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    num_checks++;
    if (got !== ex) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic guard(input int k);
    if (k >= 200) begin
      failures++;
      results();
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
      if (o_awready === 1'b1) i_awvalid <= 0;
      if (o_wready === 1'b1) i_wvalid <= 0;
    end while (o_bvalid !== 1'b1 && n < 200);
    rs = o_bresp;
    i_bready <= 0;
    guard(n);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_core_clk);
    i_araddr <= a;
    i_arvalid <= 1;
    i_rready <= 1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
      if (o_arready === 1'b1) i_arvalid <= 0;
    end while (o_rvalid !== 1'b1 && n < 200);
    rv = {32'h0, o_rdata};
    rs = o_rresp;
    i_rready <= 0;
    guard(n);
  endtask
  task automatic rd64(input logic [7:0] a);
    logic [31:0] lo;
    rd(a);
    lo = rv[31:0];
    rd(a + 8'h4);
    rv = {rv[31:0], lo};
  endtask
  // Start, stimulus, second edge, report wait
  task automatic go(input logic [31:0] v);
    wr(gating_pkg::OFF_CTRL, v | 32'h1 << gating_pkg::CTRL_START);
    cyc(4);
  endtask
  task automatic feed(input int k, input logic [7:0] cv, ev, input logic bv);
    @(posedge i_core_clk);
    i_clk_inc <= cv;
    i_err_inc <= ev;
    i_blk_inc <= bv;
    cyc(k);
    i_clk_inc <= 0;
    i_err_inc <= 0;
    i_blk_inc <= 0;
  endtask
  task automatic tick();
    @(posedge i_core_clk);
    i_sec_level <= 1;
    cyc(8);
    i_sec_level <= 0;
    cyc(8);
  endtask
  task automatic wait_rep(output int k);
    k = 0;
    do begin
      @(posedge i_core_clk);
      k++;
    end while (o_report !== 1'b1 && k < 200);
    guard(k);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cyc(12);
    i_rst <= 0;
    cyc(2);
    rd(gating_pkg::OFF_PERIOD);
    chk("period rst", 64'(gating_pkg::RST_PERIOD), rv);
    wr(gating_pkg::OFF_PERIOD, 0);
    rd(gating_pkg::OFF_PERIOD);
    chk("period min", 64'(gating_pkg::PERIOD_MIN), rv);
    wr(gating_pkg::OFF_PERIOD, 32'hffffffff);
    rd(gating_pkg::OFF_PERIOD);
    chk("period max", 64'(gating_pkg::PERIOD_MAX), rv);
    rd(8'h2c);
    chk("unmapped", {30'h0, gating_pkg::RESP_SLVERR, 32'h0}, {30'h0, rs, rv[31:0]});
    $display("test registers done");
    c = cw(0, 0, gating_pkg::IVL_500, 0, 0);
    wr(gating_pkg::OFF_CTRL, c & ~(32'h1 << gating_pkg::CTRL_COMB));
    rd(gating_pkg::OFF_STATUS);
    chk("reject", 64'h1 << gating_pkg::STAT_REJECT, rv);
    rd(gating_pkg::OFF_CTRL);
    chk("ivl kept", cw(0, 0, gating_pkg::IVL_100, 0, 0), rv);
    wr(gating_pkg::OFF_STATUS, 32'h1 << gating_pkg::STAT_REJECT);
    wr(gating_pkg::OFF_CTRL, c);
    rd(gating_pkg::OFF_CTRL);
    chk("ivl 500", c, rv);
    $display("test refusal done");
    wr(gating_pkg::OFF_PERIOD, 2);
    go(cw(gating_pkg::CYC_SINGLE, 0, 0, 0, 0));
    sum = 0;
    @(posedge i_core_clk);
    for (int j = 0; j < 30; j++) begin
      seed = lfsr(seed);
      i_clk_inc <= seed[7:0];
      sum += seed[7:0];
      @(posedge i_core_clk);
    end
    i_clk_inc <= 0;
    tick();
    chk("run 1 s", 1, o_running);
    tick();
    chk("single stop", 0, o_running);
    rd64(gating_pkg::OFF_CLK_LO);
    chk("time clk", sum, rv);
    rd(gating_pkg::OFF_SECONDS);
    chk("seconds", 2, rv);
    rd(gating_pkg::OFF_STATUS);
    chk("done", 64'h1 << gating_pkg::STAT_DONE, rv);
    $display("test single time done");
    wr(gating_pkg::OFF_PERIOD, 1);
    go(cw(0, 0, 0, 0, 0));
    feed(10, 7, 0, 0);
    tick();
    chk("repeat run", 1, o_running);
    feed(10, 5, 0, 0);
    rd64(gating_pkg::OFF_CLK_LO);
    chk("held", 70, rv);
    tick();
    rd64(gating_pkg::OFF_CLK_LO);
    chk("cleared", 50, rv);
    wr(gating_pkg::OFF_CTRL, 32'h1 << gating_pkg::CTRL_STOP);
    $display("test repeat done");
    // count gating ends in the target's second
    i_mixed_pattern <= 1;
    for (int u = 1; u < 4; u++) begin
      wr(gating_pkg::OFF_TARGET, u == 1 ? 4 : (u == 2 ? 0 : 2));
      go(cw(gating_pkg::CYC_SINGLE, 2'(u), 0, 0, 0));
      for (int h = 0; h < 2; h++) begin
        feed(u == 1 ? 20 : (u == 2 ? 25 : 50), u == 1 ? 250 : 0, u == 2 ? 200 : 0, u == 3);
        tick();
        chk("count run", 64'(h == 0), o_running);
      end
      rd64(gating_pkg::OFF_CLK_LO + 8'(8 * (u - 1)));
      chk("count total", u == 3 ? 100 : 10000, rv);
    end
    $display("test count gating done");
    // untimed ignores the period until stopped
    c = cw(gating_pkg::CYC_UNTIMED, 0, 0, 0, 0);
    go(c);
    tick();
    tick();
    chk("untimed run", 1, o_running);
    wr(gating_pkg::OFF_CTRL, c | 32'h1 << gating_pkg::CTRL_STOP);
    cyc(3);
    chk("untimed stop", 0, o_running);
    $display("test untimed done");
    i_clk_inc <= 1;
    for (int m = 0; m < 6; m++) begin
      c = cw(gating_pkg::CYC_UNTIMED, 0, 2'(m % 3), 1, 1'(m / 3));
      go(c);
      wait_rep(k2);
      wait_rep(k2);
      chk("cadence", gap(2'(m % 3)), 64'(k2));
      rd64(gating_pkg::OFF_CLK_LO);
      chk("live count", gap(2'(m % 3)) * (m < 3 ? 2 : 1), rv);
      wr(gating_pkg::OFF_CTRL, c | 32'h1 << gating_pkg::CTRL_STOP);
    end
    i_clk_inc <= 0;
    $display("test live done");
    results();
  end
endmodule // tb_error_measurement_gating
